/* File: include/owdr_map.svh */
`ifndef OWDR_MAP_SVH
`define OWDR_MAP_SVH
// Clock rate in kHz (40 MHz core clock)
`define OWDR_CLK_KHZ        40000
// Times as printed, in ns or us
`define OWDR_T_START_NS     3500
`define OWDR_END_OF_STREAM_TIME_NS       3500
`define OWDR_T_ACK_DLY_NS   3500
`define OWDR_T_ACK_PULSE_US 900
`define OWDR_T_SHDN_US      3500
// Cycle counts derived from the rate
`define OWDR_EOS_CYC  ((`OWDR_END_OF_STREAM_TIME_NS * (`OWDR_CLK_KHZ / 1000) + 999) / 1000)
`define OWDR_ACK_DLY_CYC \
    ((`OWDR_T_ACK_DLY_NS * (`OWDR_CLK_KHZ / 1000) + 999) / 1000)
`define OWDR_ACK_PULSE_CYC (`OWDR_T_ACK_PULSE_US * (`OWDR_CLK_KHZ / 1000))
`define OWDR_SHDN_CYC      (`OWDR_T_SHDN_US * (`OWDR_CLK_KHZ / 1000))
// Longest high inside a byte before it is abandoned; a plain bound
// chosen above the longest bit period at the slowest supported rate
`define OWDR_T_ABORT_US    1000
`define OWDR_ABORT_CYC     (`OWDR_T_ABORT_US * (`OWDR_CLK_KHZ / 1000))
// Width of the duration counters
`define OWDR_CNT_W          18
// Device address and data byte fields
`define OWDR_DEV_ADDR       8'h58
`define OWDR_ACK_REQ_BIT    7
`define OWDR_SEL_HI_BIT     6
`define OWDR_SEL_LO_BIT     5
`define OWDR_LEVEL_W        5
`define OWDR_LEVEL_RESET    5'h1f
`endif

/* File: include/owdr_pkg.sv */
package owdr_pkg;
    // Fault indications from the analog front end
    typedef struct packed {
        logic uvlo;
        logic output_overvoltage_threshold;
        logic fb_low;
        logic otp;
    } owdr_fault_t;

    // Link receiver states
    typedef enum logic [2:0] {
        OWDR_IDLE,
        OWDR_LOW,
        OWDR_HIGH,
        OWDR_ACK_WAIT,
        OWDR_ACK_PULSE
    } owdr_state_t;
endpackage

/* File: design/owdr_sync.sv */
// Three-stage input synchroniser; output follows once stages two and
// three agree, which also rejects single-cycle glitches.
module owdr_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Raw and clean level
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic       out_r;
    logic       out_nxt;

    // Shift and agree; idle level of the line is high
    always_comb begin
        sh_nxt  = {sh_r[1:0], din};
        out_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : out_r;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sh_r  <= 3'h7;
            out_r <= 1'b1;
        end else begin
            sh_r  <= sh_nxt;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule // owdr_sync

/* File: design/owdr_rx.sv */
// Overview of operation
// - Bytes arrive most significant bit first, least significant last.
// - Address byte accepted without start when line already high.
// - Zero if low at least twice high; one if high twice low.
// - Each bit measured falling edge to falling edge.
// - Address byte compared with fixed pattern, bit zero is zero.
// - Data: bit7 ack request, bits6-5 zero selectors, bits4-0 level.
// - Ack only if requested, address matches, both bytes clean.
// - Ack after fixed delay from last fall, pull low bounded time.
// - Ack is active-low open drain; host provides pull-up.
// - Undervoltage keeps switch off until indication clears.
// - Overvoltage with low feedback shuts the device down.
// - Open-LED shutdown latched until long low then high.
// - Over-temperature shuts down, resumes when indication clears.
// - Fixed device address is hex 58.
// - Level selects one of 32 steps, full scale after reset.
// - Line low longer than shutdown time enters shutdown.
// - Decoder works without configuration at any rate whose highs stay below the abort bound and whose levels last over one cycle.
`include "owdr_map.svh"
module owdr_rx (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    // Control pin, open drain
    input  wire logic                    ctrl_in,
    output logic                         ctrl_out,
    output logic                         ctrl_oe_n,
    // Analog indications
    input  owdr_pkg::owdr_fault_t        fault,
    // Outputs to the regulator
    output logic [`OWDR_LEVEL_W-1:0]     level,
    output logic                         switch_en,
    output logic                         shutdown,
    output logic                         open_led_latched,
    output logic                         rx_error,
    output logic                         cmd_valid
);
    import owdr_pkg::*;

    localparam logic [`OWDR_CNT_W-1:0] EOS_CYC =
        `OWDR_CNT_W'(`OWDR_EOS_CYC);
    localparam logic [`OWDR_CNT_W-1:0] ACK_DLY_CYC =
        `OWDR_CNT_W'(`OWDR_ACK_DLY_CYC);
    localparam logic [`OWDR_CNT_W-1:0] ACK_PULSE_CYC =
        `OWDR_CNT_W'(`OWDR_ACK_PULSE_CYC);
    localparam logic [`OWDR_CNT_W-1:0] SHDN_CYC =
        `OWDR_CNT_W'(`OWDR_SHDN_CYC);
    localparam logic [`OWDR_CNT_W-1:0] ABORT_CYC =
        `OWDR_CNT_W'(`OWDR_ABORT_CYC);
    localparam logic [`OWDR_CNT_W-1:0] CNT_MAX = '1;

    // Ratio test: 2 = zero, 1 = one, 0 = neither; no rate setting
    function automatic logic [1:0] bit_decode(
        input logic [`OWDR_CNT_W-1:0] t_low,
        input logic [`OWDR_CNT_W-1:0] t_high);
        logic [`OWDR_CNT_W:0] lo2;
        logic [`OWDR_CNT_W:0] hi2;
        begin
            lo2 = {t_low, 1'b0};
            hi2 = {t_high, 1'b0};
            if ({1'b0, t_low} >= hi2)
                bit_decode = 2'h2;
            else if ({1'b0, t_high} >= lo2)
                bit_decode = 2'h1;
            else
                bit_decode = 2'h0;
        end
    endfunction

    // Saturating increment shared by all duration counters
    function automatic logic [`OWDR_CNT_W-1:0] sat_inc(
        input logic [`OWDR_CNT_W-1:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + `OWDR_CNT_W'(1);
    endfunction

    logic line;
    owdr_sync u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      (ctrl_in),
        .dout     (line)
    );

    owdr_state_t               st_r,      st_nxt;
    logic [`OWDR_CNT_W-1:0]    lo_cnt_r,  lo_cnt_nxt;
    logic [`OWDR_CNT_W-1:0]    hi_cnt_r,  hi_cnt_nxt;
    logic [`OWDR_CNT_W-1:0]    tmr_r,     tmr_nxt;
    logic [7:0]                sh_r,      sh_nxt;
    logic [3:0]                nbit_r,    nbit_nxt;
    logic                      byte_r,    byte_nxt;
    logic [7:0]                addr_r,    addr_nxt;
    logic                      err_r,     err_nxt;
    logic [`OWDR_LEVEL_W-1:0]  level_r,   level_nxt;
    logic                      ack_on_r,  ack_on_nxt;
    logic                      valid_r,   valid_nxt;
    logic                      line_d_r;
    logic [`OWDR_CNT_W-1:0]    shdn_cnt_r, shdn_cnt_nxt;
    logic                      shdn_r,    shdn_nxt;
    logic                      oled_r,    oled_nxt;
    logic                      oled_arm_r, oled_arm_nxt;

    logic       fall;
    logic       rise;
    logic [1:0] dec;
    logic       ack_due;
    logic [7:0] full_byte;

    assign fall = line_d_r & ~line;
    assign rise = ~line_d_r & line;
    assign dec  = bit_decode(lo_cnt_r, hi_cnt_r);
    assign full_byte = {sh_r[6:0], dec[0]};

    // The fall that opens the end-of-stream low closes the eighth bit;
    // the byte is only acted on once that low has lasted the end time,
    // so a ninth bit arriving early is caught as an error.
    always_comb begin
        st_nxt     = st_r;
        lo_cnt_nxt = lo_cnt_r;
        hi_cnt_nxt = hi_cnt_r;
        tmr_nxt    = tmr_r;
        sh_nxt     = sh_r;
        nbit_nxt   = nbit_r;
        byte_nxt   = byte_r;
        addr_nxt   = addr_r;
        err_nxt    = err_r;
        level_nxt  = level_r;
        ack_on_nxt = 1'b0;
        valid_nxt  = 1'b0;
        ack_due    = 1'b0;
        case (st_r)
            OWDR_IDLE: begin
                // Line high here counts as a start; no prior low needed
                if (fall) begin
                    st_nxt     = OWDR_LOW;
                    lo_cnt_nxt = '0;
                    hi_cnt_nxt = '0;
                end
            end
            OWDR_LOW: begin
                lo_cnt_nxt = sat_inc(lo_cnt_r);
                if (line) begin
                    st_nxt = OWDR_HIGH;
                end else if (nbit_r == 4'h8 &&
                             lo_cnt_r >= EOS_CYC) begin
                    // All eight bits in; this low is no bit, so no
                    // ratio test is made on it
                    if (!byte_r) begin
                        addr_nxt = sh_r;
                        byte_nxt = 1'b1;
                        nbit_nxt = 4'h0;
                        sh_nxt   = 8'h00;
                        st_nxt   = OWDR_IDLE;
                    end else begin
                        ack_due = sh_r[`OWDR_ACK_REQ_BIT] &&
                                  addr_r == `OWDR_DEV_ADDR &&
                                  !err_r;
                        if (addr_r == `OWDR_DEV_ADDR && !err_r &&
                            !sh_r[`OWDR_SEL_HI_BIT] &&
                            !sh_r[`OWDR_SEL_LO_BIT]) begin
                            level_nxt = sh_r[`OWDR_LEVEL_W-1:0];
                            valid_nxt = 1'b1;
                        end
                        byte_nxt = 1'b0;
                        nbit_nxt = 4'h0;
                        sh_nxt   = 8'h00;
                        err_nxt  = 1'b0;
                        // Delay counts from the last falling edge
                        tmr_nxt  = lo_cnt_r;
                        st_nxt   = ack_due ? OWDR_ACK_WAIT : OWDR_IDLE;
                    end
                end
            end
            OWDR_HIGH: begin
                hi_cnt_nxt = sat_inc(hi_cnt_r);
                if (fall) begin
                    // Interval closed; shift the decoded bit
                    if (nbit_r == 4'h8) begin
                        // A ninth fall before end-of-stream is a fault
                        err_nxt = 1'b1;
                    end else begin
                        if (dec == 2'h0)
                            err_nxt = 1'b1;
                        sh_nxt   = full_byte;
                        nbit_nxt = nbit_r + 4'h1;
                    end
                    lo_cnt_nxt = '0;
                    hi_cnt_nxt = '0;
                    st_nxt     = OWDR_LOW;
                end else if (hi_cnt_r >= ABORT_CYC) begin
                    // A high longer than any bit at the slowest rate
                    // abandons the transaction; a lower bound would cut
                    // the long one-bits of slow hosts
                    st_nxt   = OWDR_IDLE;
                    nbit_nxt = 4'h0;
                    byte_nxt = 1'b0;
                    err_nxt  = 1'b0;
                    sh_nxt   = 8'h00;
                end
            end
            OWDR_ACK_WAIT: begin
                tmr_nxt = sat_inc(tmr_r);
                if (tmr_r >= ACK_DLY_CYC) begin
                    st_nxt     = OWDR_ACK_PULSE;
                    tmr_nxt    = '0;
                    ack_on_nxt = 1'b1;
                end
            end
            OWDR_ACK_PULSE: begin
                // Pulse width fixed at the bound so a host never waits
                // past it; pull-down released afterwards
                tmr_nxt    = sat_inc(tmr_r);
                ack_on_nxt = (tmr_r < ACK_PULSE_CYC - `OWDR_CNT_W'(1));
                if (!ack_on_nxt)
                    st_nxt = OWDR_IDLE;
            end
            default: st_nxt = OWDR_IDLE;
        endcase
        // Shutdown aborts any transaction and restores level default
        if (shdn_r) begin
            st_nxt    = OWDR_IDLE;
            nbit_nxt  = 4'h0;
            byte_nxt  = 1'b0;
            err_nxt   = 1'b0;
            level_nxt = `OWDR_LEVEL_RESET;
            ack_on_nxt = 1'b0;
        end
    end

    // Shutdown timing and open-LED latch
    always_comb begin
        shdn_cnt_nxt = line ? '0 : sat_inc(shdn_cnt_r);
        shdn_nxt     = shdn_r;
        if (!line && shdn_cnt_r >= SHDN_CYC && !ack_on_r)
            shdn_nxt = 1'b1;
        else if (rise)
            shdn_nxt = 1'b0;
        oled_arm_nxt = oled_arm_r;
        if (oled_r && !line && shdn_cnt_r >= SHDN_CYC)
            oled_arm_nxt = 1'b1;
        oled_nxt = oled_r;
        if (oled_arm_r && rise) begin
            oled_nxt     = 1'b0;
            oled_arm_nxt = 1'b0;
        end
        // Set wins over the release in the same cycle
        if (fault.output_overvoltage_threshold && fault.fb_low && switch_en)
            oled_nxt = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_r       <= OWDR_IDLE;
            lo_cnt_r   <= '0;
            hi_cnt_r   <= '0;
            tmr_r      <= '0;
            sh_r       <= 8'h00;
            nbit_r     <= 4'h0;
            byte_r     <= 1'b0;
            addr_r     <= 8'h00;
            err_r      <= 1'b0;
            level_r    <= `OWDR_LEVEL_RESET;
            ack_on_r   <= 1'b0;
            valid_r    <= 1'b0;
            line_d_r   <= 1'b1;
            shdn_cnt_r <= '0;
            shdn_r     <= 1'b0;
            oled_r     <= 1'b0;
            oled_arm_r <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            lo_cnt_r   <= lo_cnt_nxt;
            hi_cnt_r   <= hi_cnt_nxt;
            tmr_r      <= tmr_nxt;
            sh_r       <= sh_nxt;
            nbit_r     <= nbit_nxt;
            byte_r     <= byte_nxt;
            addr_r     <= addr_nxt;
            err_r      <= err_nxt;
            level_r    <= level_nxt;
            ack_on_r   <= ack_on_nxt;
            valid_r    <= valid_nxt;
            line_d_r   <= line;
            shdn_cnt_r <= shdn_cnt_nxt;
            shdn_r     <= shdn_nxt;
            oled_r     <= oled_nxt;
            oled_arm_r <= oled_arm_nxt;
        end
    end

    // Open-drain drive: output always low, enable active low
    assign ctrl_out  = 1'b0;
    assign ctrl_oe_n = ~ack_on_r;
    // Switch gated by every shutdown cause
    assign switch_en = ~shdn_r & ~oled_r & ~fault.uvlo & ~fault.otp;
    assign shutdown  = ~switch_en;
    assign level     = level_r;
    assign open_led_latched = oled_r;
    assign rx_error  = err_r;
    assign cmd_valid = valid_r;
endmodule // owdr_rx

/* File: dv/owdr_rx_assertions.sv */
`include "owdr_map.svh"
module owdr_rx_assertions (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    // Control pin
    input  wire logic                        ctrl_in,
    input  wire logic                        ctrl_out,
    input  wire logic                        ctrl_oe_n,
    // Indications and results
    input  owdr_pkg::owdr_fault_t            fault,
    input  wire logic [`OWDR_LEVEL_W-1:0]    level,
    input  wire logic                        switch_en,
    input  wire logic                        shutdown,
    input  wire logic                        open_led_latched,
    input  wire logic                        rx_error,
    input  wire logic                        cmd_valid
);
    import owdr_pkg::*;
    localparam int ACK_MAX = `OWDR_ACK_PULSE_CYC;
    logic [17:0] ack_cnt_r;
    logic [17:0] ack_cnt_nxt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Length of the current pull-down pulse, counted in helper logic
    always_comb begin
        ack_cnt_nxt = ctrl_oe_n ? 18'h0 : ack_cnt_r + 18'h1;
    end
    always_ff @(posedge core_clk) begin
        ack_cnt_r <= !nrst ? 18'h0 : ack_cnt_nxt;
    end

    a_out_zero: assert property (ctrl_out == 1'b0)
        else $error("pin data not low");
    a_shdn_inverse: assert property (shutdown == !switch_en)
        else $error("shutdown not inverse of switch enable");
    a_uvlo_off: assert property (fault.uvlo |-> !switch_en)
        else $error("switch on under undervoltage");
    a_otp_off: assert property (fault.otp |-> !switch_en)
        else $error("switch on while overheated");
    a_olp_latch: assert property (
        switch_en && fault.output_overvoltage_threshold && fault.fb_low |=> open_led_latched)
        else $error("open LED not latched");
    a_latch_off: assert property (open_led_latched |-> !switch_en)
        else $error("switch on while open LED latched");
    a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    a_level_hold: assert property (
        $changed(level) && level != 5'h1f |-> cmd_valid || $past(cmd_valid))
        else $error("level changed without command");
    a_ack_bound: assert property (ack_cnt_r <= 18'(ACK_MAX))
        else $error("acknowledge pulse too long");
    a_ack_delay: assert property (
        $fell(ctrl_oe_n) |-> !$past(ctrl_in, 100))
        else $error("acknowledge without low line before it");

    c_cmd: cover property (cmd_valid);
    c_ack: cover property ($fell(ctrl_oe_n));
    c_olp: cover property ($rose(open_led_latched));
endmodule // owdr_rx_assertions

bind owdr_rx owdr_rx_assertions u_owdr_rx_assertions (
    .core_clk(core_clk), .nrst(nrst), .ctrl_in(ctrl_in),
    .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n), .fault(fault),
    .level(level), .switch_en(switch_en), .shutdown(shutdown),
    .open_led_latched(open_led_latched), .rx_error(rx_error),
    .cmd_valid(cmd_valid)
);

/* File: dv/owdr_host.sv */
// Open-drain host; the wire goes high by pull-up when released
module owdr_host (
    // Clock
    input  wire logic core_clk,
    // High pulls the wire low
    output logic      host_low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_low = 1'b0;

    // Hold a level for n cycles; changes land just after falling edges
    task automatic hold(input logic low, input int n);
        host_low = low;
        repeat (n) @(negedge core_clk);
    endtask

    // MSB first, ratio 3:1; a bad bit has equal low and high
    task automatic send_byte(input logic [7:0] b, input int u, bad);
        for (int i = 7; i >= 0; i--) begin
            hold(1'b1, (i == bad) ? 2 * u : (b[i] ? u : 3 * u));
            hold(1'b0, (i == bad) ? 2 * u : (b[i] ? 3 * u : u));
        end
        hold(1'b1, 300); // End of stream held low, also the ack delay
    endtask

    // Idle high serves as start before the address
    task automatic send_cmd(input logic [7:0] a, d, input int u, bad);
        hold(1'b0, 300);
        send_byte(a, u, -1);
        hold(1'b0, 300);
        send_byte(d, u, bad);
        host_low = 1'b0; // Released after the delay, then sampled
    endtask
endmodule // owdr_host

/* File: dv/owdr_rx_test.sv */
`include "owdr_map.svh"
module owdr_rx_test;
    timeunit 1ns;
    timeprecision 100ps;
    import owdr_pkg::*;
    logic                     core_clk = 1'b0;
    logic                     nrst;
    logic                     host_low;
    logic                     ctrl_out;
    logic                     ctrl_oe_n;
    wire logic                ctrl_in;
    owdr_fault_t              fault;
    logic [`OWDR_LEVEL_W-1:0] level;
    logic [`OWDR_LEVEL_W-1:0] exp_level = 5'h1f;
    logic                     switch_en;
    logic                     shutdown;
    logic                     open_led_latched;
    logic                     rx_error;
    logic                     cmd_valid;
    int                       bad_count = 0;
    int                       num_checks = 0;
    int                       pulses;
    int                       ack_len;
    int                       err_seen;

    always #12.5 core_clk = ~core_clk;
    // Pull-up wire: low if either party pulls it
    assign ctrl_in = !host_low && (ctrl_oe_n || ctrl_out);

    owdr_host u_owdr_host (.core_clk(core_clk), .host_low(host_low));
    owdr_rx u_owdr_rx (
        .core_clk(core_clk), .nrst(nrst), .ctrl_in(ctrl_in),
        .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n), .fault(fault),
        .level(level), .switch_en(switch_en), .shutdown(shutdown),
        .open_led_latched(open_led_latched), .rx_error(rx_error),
        .cmd_valid(cmd_valid)
    );

    // Tally at the falling edge, where the registered outputs are settled
    always @(negedge core_clk) begin
        if (cmd_valid === 1'b1) pulses++;
        if (ctrl_oe_n === 1'b0) ack_len++;
        if (rx_error === 1'b1) err_seen = 1;
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One command; the model decides update and acknowledge
    task automatic run(input logic [7:0] a, d, input int u, bad);
        logic ok;
        logic ack;
        ok = a == 8'h58 && d[6:5] == 2'b00 && bad < 0;
        ack = a == 8'h58 && d[7] && bad < 0;
        pulses = 0;
        ack_len = 0;
        err_seen = 0;
        u_owdr_host.send_cmd(a, d, u, bad);
        // Wait out the pulse before the next command, bounded
        for (int n = 0; n < 300 || (ctrl_oe_n === 1'b0 && n < 40000); n++)
            @(negedge core_clk);
        if (ok) exp_level = d[4:0];
        check("level", level, exp_level);
        check("cmd_valid", pulses, ok);
        check("ack", ack_len > 0 && ack_len <= 36000, ack);
        check("rx_error", err_seen, bad >= 0);
    endtask

    initial begin
        nrst = 1'b0;
        fault = 4'b0000;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        void'($urandom(32'h4ae7));
        check("level_reset", level, 5'h1f);
        run(8'h58, 8'h0a, 4, -1);
        run(8'h59, 8'h03, 4, -1);
        run(8'h58, 8'h45, 4, -1);
        run(8'h58, 8'h11, 4, 2);
        // Random levels at a fast and a slow bit rate
        for (int k = 0; k < 3; k++)
            run(8'h58, {3'b000, 5'($urandom)}, (k == 2) ? 40 : 4, -1);
        run(8'h5a, 8'h85, 4, -1);
        run(8'h58, 8'h9c, 4, -1);
        check("released", ctrl_oe_n, 1'b1);
        // Faults: {uvlo, ovp, fb_low, otp}
        fault = 4'b1000;
        @(negedge core_clk);
        check("switch_uvlo", switch_en, 1'b0);
        check("shutdown_uvlo", shutdown, 1'b1);
        fault = 4'b0001;
        @(negedge core_clk);
        check("switch_otp", switch_en, 1'b0);
        fault = 4'b0000;
        @(negedge core_clk);
        check("switch_back", switch_en, 1'b1);
        fault = 4'b0110;
        repeat (3) @(negedge core_clk);
        fault = 4'b0000;
        repeat (3) @(negedge core_clk);
        check("olp_latched", open_led_latched, 1'b1);
        check("olp_switch", switch_en, 1'b0);
        finish_test;
    end

    // Commands take about 55k cycles; cut a hang at 80k
    initial begin
        #2_000_000;
        bad_count++;
        finish_test;
    end
endmodule // owdr_rx_test
